//--- exec_unit.sv
// Local design decisions: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module exec_unit #(
  // Opcodes of the remaining instructions, defaults arbitrary.
  parameter logic [5:0] OP_REG_CHANGE = 6'h26,
  parameter logic [5:0] OP_UNCOND_BRANCH = 6'h01,
  parameter logic [5:0] OP_SKIP_GREATER = 6'h3b,
  parameter logic [5:0] OP_SKIP_MASKED = 6'h38,
  parameter logic [5:0] OP_SKIP_NO_ONES = 6'h3a,
  parameter logic [5:0] OP_SKIP_MEM_NEG = 6'h2b,
  // Cycles charged for a return branch.
  parameter logic [3:0] RETURN_CYCLES = 4'h2
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Core memory port.
  output exec_pkg::mem_req_t mem_req,
  input wire exec_pkg::mem_rsp_t mem_rsp,
  // Interrupt level logic.
  output logic level_clear,
  output logic intr_inhibit
);

  // Registered state and its next value.
  exec_pkg::core_state_t s_r;
  exec_pkg::core_state_t s_nxt;

  // Opcode of the held instruction.
  logic [5:0] op;
  assign op = s_r.instr[exec_pkg::OP_MSB:exec_pkg::OP_LSB];

  // Target of a word: address field, indexed when its flag is set.
  function automatic logic [13:0] target(input logic [23:0] w, input logic [23:0] x);
    logic [13:0] t;
    t = w[13:0];
    if (w[exec_pkg::INDEX_FLAG_POS]) begin
      t = w[13:0] + x[13:0];
    end
    return t;
  endfunction

  // Counter plus a small step, wrapping in the 14-bit space.
  function automatic logic [13:0] advance(input logic [13:0] p, input logic [1:0] k);
    return p + {12'h000, k};
  endfunction

  // Read view of the registers; unmapped offsets read zero.
  function automatic logic [31:0] read_reg(input exec_pkg::core_state_t s,
                                           input logic [7:0] off);
    logic [31:0] r;
    r = exec_pkg::RST_BUS;
    unique case (off)
      exec_pkg::OFF_CTRL: begin
        r[exec_pkg::CTRL_GO] = s.busy;
        r[exec_pkg::CTRL_IRQ_ENTRY] = s.irq_entry;
      end
      exec_pkg::OFF_STATUS: begin
        r[exec_pkg::ST_DONE_POS] = s.done;
        r[exec_pkg::ST_SKIP_POS] = s.skipped;
        r[exec_pkg::ST_BRANCH_POS] = s.branched;
        r[exec_pkg::ST_INHIBIT_POS] = s.inhibit;
        r[exec_pkg::ST_BADOP_POS] = s.bad_op;
        r[exec_pkg::ST_CYC_LSB +: 4] = s.cycles;
      end
      exec_pkg::OFF_INSTR: r = {8'h00, s.instr};
      exec_pkg::OFF_ACC_A: r = {8'h00, s.a};
      exec_pkg::OFF_ACC_B: r = {8'h00, s.b};
      exec_pkg::OFF_INDEX: r = {8'h00, s.x};
      exec_pkg::OFF_PC: r = {18'h00000, s.p};
      exec_pkg::OFF_OVF: r = {31'h00000000, s.ovf};
      default: r = exec_pkg::RST_BUS;
    endcase
    return r;
  endfunction

  // Outcome of a test-and-skip instruction.
  function automatic logic skip_taken(input logic [5:0] o, input logic [23:0] a,
                                      input logic [23:0] b, input logic [23:0] m);
    logic t;
    t = 1'b0;
    if (o == OP_SKIP_GREATER) begin
      t = $signed(a) > $signed(m);
    end else if (o == OP_SKIP_MASKED) begin
      t = ((a ^ m) & b) == exec_pkg::RST_WORD;
    end else if (o == OP_SKIP_NO_ONES) begin
      t = (a & m) == exec_pkg::RST_WORD;
    end else if (o == OP_SKIP_MEM_NEG) begin
      t = m[exec_pkg::SIGN_POS];
    end
    return t;
  endfunction

  // Whether an opcode reads a memory operand.
  function automatic logic needs_operand(input logic [5:0] o);
    return (o == exec_pkg::OP_RETURN_BRANCH) || (o == OP_SKIP_GREATER) ||
           (o == OP_SKIP_MASKED) || (o == OP_SKIP_NO_ONES) || (o == OP_SKIP_MEM_NEG);
  endfunction

  // Whether an opcode belongs to this unit at all.
  function automatic logic known_op(input logic [5:0] o);
    return (o == OP_REG_CHANGE) || (o == OP_UNCOND_BRANCH) ||
           (o == exec_pkg::OP_INDEX_BRANCH) || (o == exec_pkg::OP_MARK_BRANCH) ||
           needs_operand(o);
  endfunction

  // Next state: bus slave, register writes and the sequencer.
  always_comb begin
    logic [23:0] w;
    logic [23:0] xi;
    logic [24:0] sum;
    w = mem_rsp.rdata;
    xi = s_r.x + 24'h000001;
    sum = {1'b0, s_r.operand} + 25'h0000001;
    s_nxt = s_r;
    s_nxt.level_clear = 1'b0;
    s_nxt.hreadyout = 1'b1;
    s_nxt.wr_pend = 1'b0;

    // Data phase of a write. Values are held while the unit is busy so
    // software cannot tear an instruction in flight.
    if (s_r.wr_pend) begin
      unique case (s_r.wr_addr)
        exec_pkg::OFF_CTRL: begin
          if (hwdata[exec_pkg::CTRL_GO] && !s_r.busy) begin
            s_nxt.busy = 1'b1;
            s_nxt.st = exec_pkg::ST_DECODE;
            s_nxt.irq_entry = hwdata[exec_pkg::CTRL_IRQ_ENTRY];
            s_nxt.done = 1'b0;
            s_nxt.skipped = 1'b0;
            s_nxt.branched = 1'b0;
            s_nxt.bad_op = 1'b0;
            s_nxt.inhibit = 1'b0;
            s_nxt.cycles = 4'h0;
          end
        end
        exec_pkg::OFF_STATUS: s_nxt.done = 1'b0;
        exec_pkg::OFF_INSTR: if (!s_r.busy) s_nxt.instr = hwdata[23:0];
        exec_pkg::OFF_ACC_A: if (!s_r.busy) s_nxt.a = hwdata[23:0];
        exec_pkg::OFF_ACC_B: if (!s_r.busy) s_nxt.b = hwdata[23:0];
        exec_pkg::OFF_INDEX: if (!s_r.busy) s_nxt.x = hwdata[23:0];
        exec_pkg::OFF_PC: if (!s_r.busy) s_nxt.p = hwdata[13:0];
        exec_pkg::OFF_OVF: if (!s_r.busy) s_nxt.ovf = hwdata[0];
        default: s_nxt.wr_pend = 1'b0;
      endcase
    end

    // Address phase: read data is sampled now so it stands in the data phase.
    if (hsel && hready && htrans[1]) begin
      s_nxt.hrdata = read_reg(s_r, haddr[7:0]);
      s_nxt.wr_pend = hwrite;
      s_nxt.wr_addr = haddr[7:0];
    end

    unique case (s_r.st)
      exec_pkg::ST_IDLE: begin
        s_nxt.mem.req = 1'b0;
      end
      exec_pkg::ST_DECODE: begin
        if (op == OP_REG_CHANGE) begin
          // No address is formed; the step completes at once.
          s_nxt.cycles = exec_pkg::CYC_ONE;
          unique case (s_r.instr[exec_pkg::RCH_MSB:exec_pkg::RCH_LSB])
            exec_pkg::RCH_SWAP: begin
              s_nxt.a = s_r.b;
              s_nxt.b = s_r.a;
            end
            exec_pkg::RCH_B_TO_A: begin
              s_nxt.a = s_r.b;
              s_nxt.b = exec_pkg::RST_WORD;
            end
            exec_pkg::RCH_A_TO_B: begin
              s_nxt.b = s_r.a;
              s_nxt.a = exec_pkg::RST_WORD;
            end
            exec_pkg::RCH_ZERO: begin
              s_nxt.a = exec_pkg::RST_WORD;
              s_nxt.b = exec_pkg::RST_WORD;
            end
          endcase
          s_nxt.p = advance(s_r.p, 2'h1);
          s_nxt.st = exec_pkg::ST_IDLE;
          s_nxt.busy = 1'b0;
          s_nxt.done = 1'b1;
        end else if (!known_op(op)) begin
          // Foreign opcodes are refused and leave every register alone.
          s_nxt.bad_op = 1'b1;
          s_nxt.st = exec_pkg::ST_IDLE;
          s_nxt.busy = 1'b0;
          s_nxt.done = 1'b1;
        end else begin
          // Index before any increment, so an indexed index-branch uses
          // the old index for its target.
          s_nxt.ea = target(s_r.instr, s_r.x);
          if (op == OP_UNCOND_BRANCH && s_r.instr[exec_pkg::INDIRECT_POS]) begin
            s_nxt.level_clear = 1'b1;
          end
          if (s_r.instr[exec_pkg::INDIRECT_POS]) begin
            s_nxt.mem = '{req: 1'b1, we: 1'b0, addr: target(s_r.instr, s_r.x),
                          wdata: exec_pkg::RST_WORD};
            s_nxt.st = exec_pkg::ST_INDIRECT;
          end else if (needs_operand(op)) begin
            s_nxt.mem = '{req: 1'b1, we: 1'b0, addr: target(s_r.instr, s_r.x),
                          wdata: exec_pkg::RST_WORD};
            s_nxt.st = exec_pkg::ST_OPERAND;
          end else begin
            s_nxt.st = exec_pkg::ST_EXECUTE;
          end
        end
      end
      exec_pkg::ST_INDIRECT: begin
        // Each level may index again and chain further without limit.
        if (mem_rsp.ack) begin
          s_nxt.ea = target(w, s_r.x);
          s_nxt.cycles = s_r.cycles + 4'h1;
          s_nxt.mem.addr = target(w, s_r.x);
          if (w[exec_pkg::INDIRECT_POS]) begin
            s_nxt.st = exec_pkg::ST_INDIRECT;
          end else if (needs_operand(op)) begin
            s_nxt.st = exec_pkg::ST_OPERAND;
          end else begin
            s_nxt.mem.req = 1'b0;
            s_nxt.st = exec_pkg::ST_EXECUTE;
          end
        end
      end
      exec_pkg::ST_OPERAND: begin
        if (mem_rsp.ack) begin
          s_nxt.mem.req = 1'b0;
          s_nxt.operand = w;
          s_nxt.st = exec_pkg::ST_EXECUTE;
        end
      end
      exec_pkg::ST_EXECUTE: begin
        s_nxt.st = exec_pkg::ST_IDLE;
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
        if (op == OP_UNCOND_BRANCH) begin
          s_nxt.p = s_r.ea;
          s_nxt.branched = 1'b1;
          s_nxt.cycles = s_r.cycles + exec_pkg::CYC_ONE;
        end else if (op == exec_pkg::OP_INDEX_BRANCH) begin
          s_nxt.x = xi;
          // Only the tested bit decides; the upper nine bits just count.
          if (xi[exec_pkg::XTEST_POS]) begin
            s_nxt.p = s_r.ea;
            s_nxt.branched = 1'b1;
            s_nxt.inhibit = 1'b1;
            s_nxt.cycles = s_r.cycles + exec_pkg::CYC_ONE;
          end else begin
            s_nxt.p = advance(s_r.p, 2'h1);
            s_nxt.cycles = s_r.cycles + exec_pkg::CYC_TWO;
          end
        end else if (op == exec_pkg::OP_MARK_BRANCH) begin
          // The counter already holds the return point on interrupt entry.
          s_nxt.mem = '{req: 1'b1, we: 1'b1, addr: s_r.ea,
                        wdata: {s_r.ovf, 9'h000, s_r.p}};
          s_nxt.st = exec_pkg::ST_STORE;
          s_nxt.busy = 1'b1;
          s_nxt.done = 1'b0;
        end else if (op == exec_pkg::OP_RETURN_BRANCH) begin
          // Memory is only read, never written back.
          s_nxt.p = sum[13:0];
          s_nxt.ovf = s_r.ovf | s_r.operand[exec_pkg::SIGN_POS];
          s_nxt.branched = 1'b1;
          s_nxt.cycles = s_r.cycles + RETURN_CYCLES;
        end else if (skip_taken(op, s_r.a, s_r.b, s_r.operand)) begin
          s_nxt.p = advance(s_r.p, 2'h2);
          s_nxt.skipped = 1'b1;
          s_nxt.cycles = s_r.cycles + exec_pkg::CYC_THREE;
        end else begin
          s_nxt.p = advance(s_r.p, 2'h1);
          s_nxt.cycles = s_r.cycles + exec_pkg::CYC_TWO;
        end
      end
      exec_pkg::ST_STORE: begin
        if (mem_rsp.ack) begin
          s_nxt.mem.req = 1'b0;
          s_nxt.mem.we = 1'b0;
          s_nxt.p = advance(s_r.ea, 2'h1);
          s_nxt.branched = 1'b1;
          s_nxt.cycles = s_r.cycles + exec_pkg::CYC_TWO;
          s_nxt.st = exec_pkg::ST_IDLE;
          s_nxt.busy = 1'b0;
          s_nxt.done = 1'b1;
        end
      end
    endcase
  end

  // State register; reset leaves the bus ready and everything else clear.
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
      s_r.hreadyout <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs come straight from the state register.
  assign hrdata = s_r.hrdata;
  assign hreadyout = s_r.hreadyout;
  // Every transfer is answered OKAY.
  assign hresp = 1'b0;
  assign mem_req = s_r.mem;
  assign level_clear = s_r.level_clear;
  assign intr_inhibit = s_r.inhibit;

endmodule

//--- exec_pkg.sv
package exec_pkg;

  // Word and address widths.
  localparam int WORD_W = 24;
  localparam int ADDR_W = 14;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_INSTR = 8'h08;
  localparam logic [7:0] OFF_ACC_A = 8'h0c;
  localparam logic [7:0] OFF_ACC_B = 8'h10;
  localparam logic [7:0] OFF_INDEX = 8'h14;
  localparam logic [7:0] OFF_PC = 8'h18;
  localparam logic [7:0] OFF_OVF = 8'h1c;

  // Control and status bit positions.
  localparam int CTRL_GO = 0;
  localparam int CTRL_IRQ_ENTRY = 1;
  localparam int ST_DONE_POS = 0;
  localparam int ST_SKIP_POS = 1;
  localparam int ST_BRANCH_POS = 2;
  localparam int ST_INHIBIT_POS = 3;
  localparam int ST_BADOP_POS = 4;
  localparam int ST_CYC_LSB = 8;

  // Word field positions; word bit 0 (sign) is the msb here.
  localparam int SIGN_POS = 23;
  localparam int INDEX_FLAG_POS = 22;
  localparam int OP_MSB = 20;
  localparam int OP_LSB = 15;
  localparam int INDIRECT_POS = 14;
  localparam int XTEST_POS = 14;
  localparam int RCH_MSB = 13;
  localparam int RCH_LSB = 12;

  // Register-change function codes.
  localparam logic [1:0] RCH_SWAP = 2'h0;
  localparam logic [1:0] RCH_B_TO_A = 2'h1;
  localparam logic [1:0] RCH_A_TO_B = 2'h2;
  localparam logic [1:0] RCH_ZERO = 2'h3;

  // Opcodes that are fixed by known instruction images.
  localparam logic [5:0] OP_INDEX_BRANCH = 6'h21;
  localparam logic [5:0] OP_MARK_BRANCH = 6'h23;
  localparam logic [5:0] OP_RETURN_BRANCH = 6'h29;

  // Timing counts in memory cycles.
  localparam logic [3:0] CYC_ONE = 4'h1;
  localparam logic [3:0] CYC_TWO = 4'h2;
  localparam logic [3:0] CYC_THREE = 4'h3;

  // Reset values.
  localparam logic [23:0] RST_WORD = 24'h000000;
  localparam logic [31:0] RST_BUS = 32'h00000000;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE, ST_DECODE, ST_INDIRECT, ST_OPERAND, ST_EXECUTE, ST_STORE
  } exec_state_t;

  // Request to core memory.
  typedef struct packed {
    logic req;
    logic we;
    logic [13:0] addr;
    logic [23:0] wdata;
  } mem_req_t;

  // Answer from core memory.
  typedef struct packed {
    logic ack;
    logic [23:0] rdata;
  } mem_rsp_t;

  // Whole state of the execution unit.
  typedef struct packed {
    exec_state_t st;
    logic [23:0] a;
    logic [23:0] b;
    logic [23:0] x;
    logic [13:0] p;
    logic ovf;
    logic [23:0] instr;
    logic [23:0] operand;
    logic [13:0] ea;
    logic busy;
    logic done;
    logic skipped;
    logic branched;
    logic bad_op;
    logic irq_entry;
    logic inhibit;
    logic level_clear;
    logic [3:0] cycles;
    mem_req_t mem;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] hrdata;
    logic hreadyout;
  } core_state_t;

endpackage

//--- core_mem_model.sv
`timescale 1ns/1ps
// Core memory behind the execution unit; answers after zero or two idle cycles in turn.
module core_mem_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Request in, answer out.
  input wire exec_pkg::mem_req_t req,
  output exec_pkg::mem_rsp_t rsp
);
  // Word store; the bench may preset words between instructions.
  logic [23:0] mem [0:16383];
  // Idle cycles counted for the waiting request.
  logic [1:0] wait_r;
  // Alternates prompt and slow answers.
  logic slow_r;

  // One answer per request; read data is scrambled outside the answer cycle.
  always @(posedge clk) begin
    if (rst) begin
      rsp <= '0;
      wait_r <= 2'h0;
      slow_r <= 1'b0;
    end else if (req.req && !rsp.ack && wait_r == {slow_r, 1'b0}) begin
      rsp.ack <= 1'b1;
      rsp.rdata <= req.we ? ~req.wdata : mem[req.addr];
      if (req.we) begin
        mem[req.addr] <= req.wdata;
      end
      wait_r <= 2'h0;
      slow_r <= ~slow_r;
    end else begin
      // A stale value would hide a late sample, so the lines keep changing.
      rsp.ack <= 1'b0;
      rsp.rdata <= ~rsp.rdata;
      if (req.req && !rsp.ack) begin
        wait_r <= wait_r + 2'h1;
      end
    end
  end
endmodule

//--- exec_unit_checker.sv
`timescale 1ns/1ps
// Port-level checks of the execution unit.
module exec_unit_checker (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Bus side.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // Memory side.
  input wire exec_pkg::mem_req_t mem_req,
  input wire exec_pkg::mem_rsp_t mem_rsp,
  // Interrupt level side.
  input wire logic level_clear,
  input wire logic intr_inhibit
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Address phase of a write to the control word.
  logic ctrl_wr;
  assign ctrl_wr = hsel && htrans[1] && hready && hwrite && haddr[7:0] == 8'h00;
  // A memory request still waiting for its answer.
  logic pend;
  assign pend = mem_req.req && !mem_rsp.ack;

  resp_okay_a: assert property (hresp == 1'b0) else $error("bus response not okay");
  ready_up_a: assert property (!$past(rst) |-> hreadyout) else $error("ready low after reset");
  zero_wait_a: assert property (hsel && htrans[1] && hready |=> hreadyout)
    else $error("bus transfer stalled");
  req_hold_a: assert property (pend |=> mem_req.req) else $error("request dropped early");
  req_stable_a: assert property (pend |=> $stable(mem_req.addr) && $stable(mem_req.we)
    && $stable(mem_req.wdata)) else $error("request changed before answer");
  mark_word_a: assert property (mem_req.req && mem_req.we |-> mem_req.wdata[22:14] == 9'h000)
    else $error("stored mark word has bits set");
  clear_pulse_a: assert property (level_clear |=> !level_clear) else $error("clear too long");
  clear_fetch_a: assert property (level_clear |-> ##[0:4] (mem_req.req && !mem_req.we))
    else $error("no indirect fetch after clear");
  inhibit_hold_a: assert property ($fell(intr_inhibit) |-> $past(ctrl_wr) ||
    $past(ctrl_wr, 2) || $past(ctrl_wr, 3)) else $error("inhibit dropped without go");

  // Main scenarios reached.
  cover property (level_clear);
  cover property ($rose(intr_inhibit));
  cover property (mem_req.req && mem_req.we && mem_rsp.ack);
  cover property (pend ##1 pend);
endmodule

bind exec_unit exec_unit_checker chk_i (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .mem_req(mem_req), .mem_rsp(mem_rsp), .level_clear(level_clear),
  .intr_inhibit(intr_inhibit));

//--- exec_unit_tb_top.sv
`timescale 1ns/1ps
// Self-checking bench: registers over the bus, memory model behind.
module exec_unit_tb_top;
  // Opcodes handed to the unit; the values are arbitrary.
  localparam logic [5:0] OP_RC = 6'h26;
  localparam logic [5:0] OP_BR = 6'h01;
  localparam logic [5:0] SKIP_OPS [4] = '{6'h3b, 6'h38, 6'h3a, 6'h2b};
  localparam logic [3:0] RET_CYC = 4'h2;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic level_clear;
  logic intr_inhibit;
  exec_pkg::mem_req_t mem_req;
  exec_pkg::mem_rsp_t mem_rsp;
  int n_errors = 0;
  int check_count = 0;
  int lc_n = 0;
  int k;
  int i;
  logic [23:0] seed = 24'h000006;
  logic [23:0] a, b, m, x, w;
  logic [13:0] t;
  logic sk;
  // Register images: v is written, r is read back, index is offset over four.
  logic [31:0] v [8];
  logic [31:0] r [8];
  logic [31:0] d;
  logic [31:0] ctrl_v = 32'h1;

  always #20 clk = ~clk;
  // Counts clear pulses towards the interrupt levels.
  always @(posedge clk) begin
    if (level_clear === 1'b1) begin
      lc_n <= lc_n + 1;
    end
  end

  exec_unit #(.OP_REG_CHANGE(OP_RC), .OP_UNCOND_BRANCH(OP_BR), .OP_SKIP_GREATER(SKIP_OPS[0]),
    .OP_SKIP_MASKED(SKIP_OPS[1]), .OP_SKIP_NO_ONES(SKIP_OPS[2]),
    .OP_SKIP_MEM_NEG(SKIP_OPS[3]), .RETURN_CYCLES(RET_CYC)) dut (.clk(clk), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .mem_req(mem_req), .mem_rsp(mem_rsp), .level_clear(level_clear),
    .intr_inhibit(intr_inhibit));
  core_mem_model mem_m (.clk(clk), .rst(rst), .req(mem_req), .rsp(mem_rsp));

  // Random words from a shift register, fixed start.
  function automatic logic [23:0] lfsr();
    seed = {seed[22:0], seed[23] ^ seed[22] ^ seed[21] ^ seed[16]};
    return seed;
  endfunction
  // Builds an instruction word; word bit 0 is the msb.
  function automatic logic [23:0] mk(input logic [5:0] op, input logic ix, input logic ind,
    input logic [13:0] ad);
    return {1'b0, ix, 1'b0, op, ind, ad};
  endfunction
  // One single bus transfer; read data lands in d.
  task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, ad};
    hwrite <= wr;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    d = hrdata;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    if (^e !== 1'bx) begin
      check_count++;
      if (g !== e) begin
        $display("mismatch %s expected %h seen %h", nm, e, g);
        n_errors++;
      end
    end
  endtask
  // Loads the registers, starts one instruction, waits for done, reads all back.
  task automatic exe(input logic [23:0] in, ia, ib, ix, ip, input logic io);
    v[2] = {8'h0, in};
    v[3] = {8'h0, ia};
    v[4] = {8'h0, ib};
    v[5] = {8'h0, ix};
    v[6] = {18'h0, ip[13:0]};
    v[7] = {31'h0, io};
    for (k = 2; k < 8; k++) bus(1'b1, 8'(k * 4), v[k]);
    bus(1'b1, exec_pkg::OFF_STATUS, 32'h0);
    bus(1'b1, exec_pkg::OFF_CTRL, ctrl_v);
    d = 32'h0;
    for (k = 0; k < 40 && d[0] !== 1'b1; k++) bus(1'b0, exec_pkg::OFF_STATUS, 32'h0);
    for (k = 0; k < 8; k++) begin
      bus(1'b0, 8'(k * 4), 32'h0);
      r[k] = d;
    end
  endtask
  task automatic verify(input logic [31:0] ea, eb, ex, ep, eo, ec, es, ei);
    chk("done", 1, r[1][0]);
    chk("bad_op", 0, r[1][4]);
    chk("acc_a", ea, r[3]);
    chk("acc_b", eb, r[4]);
    chk("index", ex, r[5]);
    chk("pc", ep, r[6]);
    chk("ovf", eo, r[7]);
    chk("cycles", ec, r[1][11:8]);
    chk("skip", es, r[1][1]);
    chk("inhibit", ei, r[1][3]);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // A hang counts as a failure after far more than the run needs.
  initial begin
    #800000;
    n_errors++;
    tally_and_finish();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped", 0, d);
    // Register change; set index and indirect bits must be ignored.
    for (i = 0; i < 4; i++) begin
      a = lfsr();
      b = lfsr();
      exe(mk(OP_RC, 1'b1, 1'b1, 14'(i << 12)), a, b, 0, 24'h100, 1'b0);
      // The counter simply moves on to the next instruction in sequence.
      verify(i < 2 ? b : 0, i[0] ? 0 : a, 0, 32'h101, 0, 1, 0, 0);
    end
    // Unconditional branch: direct, indexed, one indirect level.
    mem_m.mem[14'h0300] = 24'h000456;
    exe(mk(OP_BR, 1'b0, 1'b0, 14'h0234), 0, 0, 0, 24'h100, 1'b0);
    verify(0, 0, 0, 32'h234, 0, 1, 0, 0);
    exe(mk(OP_BR, 1'b1, 1'b0, 14'h0100), 0, 0, 24'h10, 24'h100, 1'b0);
    verify(0, 0, 32'h10, 32'h110, 0, 1, 0, 0);
    exe(mk(OP_BR, 1'b0, 1'b1, 14'h0300), 0, 0, 0, 24'h100, 1'b0);
    verify(0, 0, 0, 32'h456, 0, 2, 0, 0);
    chk("level_clear", 1, lc_n);
    // Index branch: taken, taken indexed with high bits, two not taken.
    for (i = 0; i < 4; i++) begin
      x = i == 0 ? 24'h003fff : i == 1 ? 24'hffbfff : i == 2 ? 24'h007fff : 24'hffffff;
      w = x + 24'h1;
      t = 14'h0500 + (i[0] ? x[13:0] : 14'h0);
      exe(mk(exec_pkg::OP_INDEX_BRANCH, i[0], 1'b0, 14'h0500), 0, 0, x, 24'h100, 1'b0);
      verify(0, 0, w, w[14] ? t : 14'h0101, 0, w[14] ? 1 : 2, 0, w[14]);
    end
    // Mark and branch; the second run is entered as an interrupt.
    for (i = 0; i < 2; i++) begin
      ctrl_v = i[0] ? 32'h3 : 32'h1;
      exe(mk(exec_pkg::OP_MARK_BRANCH, 1'b0, 1'b0, 14'h0522), 0, 0, 0, 24'h0123, ~i[0]);
      // A logical not keeps the expected flag one bit wide in the 32-bit argument.
      verify(0, 0, 0, 32'h523, !i[0], 2, 0, 0);
      chk("mark_word", {~i[0], 9'h0, 14'h0123}, mem_m.mem[14'h0522]);
    end
    ctrl_v = 32'h1;
    // Return branch: carry out of the low bits, overflow kept and left clear.
    for (i = 0; i < 3; i++) begin
      w = i == 0 ? 24'h803fff : 24'h000111;
      mem_m.mem[14'h0400] = w;
      t = w[13:0] + 14'h1;
      exe(mk(exec_pkg::OP_RETURN_BRANCH, 1'b0, 1'b0, 14'h0400), 0, 0, 0, 24'h100, i == 1);
      verify(0, 0, 0, t, w[23] | (i == 1), RET_CYC, 0, 0);
      chk("ret_word", w, mem_m.mem[14'h0400]);
    end
    // Four skip tests; equal operands with an empty mask, then complements, then random.
    for (i = 0; i < 24; i++) begin
      a = lfsr();
      b = lfsr();
      m = lfsr();
      if (i % 6 == 0) begin
        m = a;
        b = 24'h0;
      end
      if (i % 6 == 1) m = ~a;
      mem_m.mem[14'h0600] = m;
      case (i / 6)
        0: sk = $signed(a) > $signed(m);
        1: sk = ((a ^ m) & b) == 24'h0;
        2: sk = (a & m) == 24'h0;
        default: sk = m[23];
      endcase
      exe(mk(SKIP_OPS[i / 6], 1'b0, 1'b0, 14'h0600), a, b, 0, 24'h200, 1'b0);
      verify(a, b, 0, 32'h201 + sk, 0, 2 + sk, sk, 0);
      chk("skip_mem", m, mem_m.mem[14'h0600]);
    end
    // Unknown opcode is flagged and leaves the accumulator alone.
    exe(mk(6'h00, 1'b0, 1'b0, 14'h0), 24'h123456, 24'h654321, 0, 24'h100, 1'b0);
    chk("bad_op", 1, r[1][4]);
    chk("acc_a", 32'h123456, r[3]);
    tally_and_finish();
  end
endmodule
